/* File: spi_prog_defines.svh */
// Constants for the SPI programming port control block
`ifndef SPI_PROG_DEFINES_SVH
`define SPI_PROG_DEFINES_SVH

`define ROLE_SLAVE        1'b0
`define ROLE_MASTER       1'b1
`define STRAP_SETTLE      2'h3
`define SYNC_RST          5'h0c

`define CLK_FREQ_MHZ      50
`define SCK_FREQ_MHZ      20
`define SCK_ACC_STEP      7'(2 * `SCK_FREQ_MHZ)
`define SCK_ACC_MOD       7'(`CLK_FREQ_MHZ)

`define FLASH_READ_CMD    8'h03
`define CMD_BITS          6'h20
`define BYTE_LAST_BIT     3'h7

`define SVC_CODE_MSB      6
`define SVC_OFFSET_LSB    7
`define SVC_OFFSET_MSB    15
`define SVC_AUTO_UPDATE   7'h01
`define SVC_IN_APP        7'h02

`define FIFO_WIDTH        8
`define FIFO_DEPTH        32

`endif

/* File: spi_prog_pkg.sv */
// Types for the SPI programming port control block
package spi_prog_pkg;

   typedef enum logic [1:0] {M_IDLE, M_CMD, M_DATA, M_DONE} mst_state_t;

   typedef enum logic [2:0] {OP_NONE, OP_AUTO_PROG, OP_AUTO_UPDATE, OP_IN_APP, OP_RECOVERY} prog_op_t;

endpackage

/* File: spi_stream_fifo.sv */
// Byte stream FIFO with registered read data
`timescale 1ns/1ps
module spi_stream_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             ref_clk_in,
   input  wire logic             rstn_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign in_ready_out = (count_r != (AW+1)'(DEPTH));
   assign push         = in_valid_in && in_ready_out;
   // Refill the output register whenever it is empty or being drained
   assign pop          = (count_r != '0) && (!out_valid_out || out_ready_in);

   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         out_valid_out <= 1'b0;
         out_data_out  <= '0;
      end else if (pop) begin
         out_valid_out <= 1'b1;
         out_data_out  <= mem_r[rd_ptr_r];
      end else if (out_ready_in) begin
         out_valid_out <= 1'b0;
      end
   end

endmodule

/* File: spi_programming_port_control.sv */
// SPI programming port control: role strap, pin drive, fabric handover, flash reads, slave intake
`timescale 1ns/1ps
`include "spi_prog_defines.svh"
module spi_programming_port_control
   import spi_prog_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic        rstn_in,
   input  wire logic        spi_en_in,
   input  wire logic        interface_role_strap_in,
   input  wire logic        powerup_done_in,
   input  wire logic        device_blank_in,
   input  wire logic        power_fail_seen_in,
   input  wire logic        auto_update_en_in,
   input  wire logic [15:0] update_version_in,
   input  wire logic [15:0] programmed_version_in,
   input  wire logic [23:0] image_addr_in,
   input  wire logic [15:0] image_len_in,
   input  wire logic        svc_valid_in,
   input  wire logic [15:0] svc_descriptor_in,
   output logic             svc_reject_out,
   output logic [6:0]       service_code_out,
   output logic [8:0]       mailbox_word_offset_out,
   input  wire logic        jtag_prog_req_in,
   output logic             jtag_grant_out,
   input  wire logic        sck_in,
   output logic             sck_out,
   output logic             sck_oe_out,
   input  wire logic        ss_n_in,
   output logic             ss_n_out,
   output logic             ss_n_oe_out,
   input  wire logic        sdi_in,
   output logic             sdo_out,
   output logic             sdo_oe_out,
   input  wire logic        fabric_sck_in,
   input  wire logic        fabric_ss_n_in,
   input  wire logic        fabric_sdo_in,
   output logic             fabric_sdi_out,
   output logic             fabric_owns_out,
   output logic             role_master_out,
   output logic             design_init_allowed_out,
   output logic             busy_out,
   output prog_op_t         op_out,
   output logic             data_valid_out,
   input  wire logic        data_ready_in,
   output logic [7:0]       data_out,
   input  wire logic        overrun_clr_in,
   output logic             slave_overrun_out
);

   logic [4:0]  pins_raw;
   logic [4:0]  sync1_r;
   logic [4:0]  sync2_r;
   logic        en_s;
   logic        strap_s;
   logic        ss_s;
   logic        sck_s;
   logic        sdi_s;
   logic        sck_prev_r;
   logic [1:0]  settle_r;
   logic        role_valid_r;
   logic        role_r;
   logic        pu_pend_r;
   logic        master_role;
   logic        master_ok;
   logic        slave_ok;
   prog_op_t    start_op;
   prog_op_t    op_r;
   logic        busy_r;
   logic        svc_reject_r;
   logic [6:0]  svc_code;
   logic        update_differs;
   logic [6:0]  acc_r;
   logic [6:0]  acc_sum;
   logic        acc_tick;
   logic        tick;
   mst_state_t  mst_state_r;
   logic [31:0] shift_r;
   logic [5:0]  bits_r;
   logic [18:0] remain_r;
   logic        sck_r;
   logic        ss_n_r;
   logic        sdo_r;
   logic        launch;
   logic [1:0]  samp_dly_r;
   logic [7:0]  rx_r;
   logic [2:0]  rxbits_r;
   logic        bit_take;
   logic        byte_done;
   logic        pend_r;
   logic [7:0]  pend_data_r;
   logic        fifo_in_ready;
   logic        overrun_r;
   logic        overrun_set;
   logic        ss_level;
   logic        drive_m;

   // Pin inputs cross into the core clock through two flops
   assign pins_raw = {sdi_in, sck_in, ss_n_in, interface_role_strap_in, spi_en_in};

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync1_r    <= `SYNC_RST;
         sync2_r    <= `SYNC_RST;
         sck_prev_r <= 1'b1;
      end else begin
         sync1_r    <= pins_raw;
         sync2_r    <= sync1_r;
         sck_prev_r <= sync2_r[3];
      end
   end

   assign en_s    = sync2_r[0];
   assign strap_s = sync2_r[1];
   assign ss_s    = sync2_r[2];
   assign sck_s   = sync2_r[3];
   assign sdi_s   = sync2_r[4];

   // Role is caught once, a few cycles after reset release, then frozen
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         settle_r     <= 2'h0;
         role_valid_r <= 1'b0;
         role_r       <= `ROLE_SLAVE;
      end else if (!role_valid_r) begin
         if (settle_r == `STRAP_SETTLE) begin
            role_r       <= strap_s;
            role_valid_r <= 1'b1;
         end else begin
            settle_r <= settle_r + 2'h1;
         end
      end
   end

   assign master_role = role_valid_r && (role_r == `ROLE_MASTER);
   assign master_ok   = master_role && en_s;
   assign slave_ok    = role_valid_r && (role_r == `ROLE_SLAVE) && en_s;

   // Choice of programming job and its source
   always_comb begin
      start_op       = OP_NONE;
      svc_code       = svc_descriptor_in[`SVC_CODE_MSB:0];
      update_differs = (update_version_in != programmed_version_in);
      if (master_ok && !busy_r) begin
         if (pu_pend_r) begin
            if (power_fail_seen_in) begin
               start_op = OP_RECOVERY;
            end else if (device_blank_in) begin
               start_op = OP_AUTO_PROG;
            end else if (auto_update_en_in && update_differs) begin
               start_op = OP_AUTO_UPDATE;
            end
         end else if (svc_valid_in) begin
            if (svc_code == `SVC_IN_APP) begin
               start_op = OP_IN_APP;
            end else if ((svc_code == `SVC_AUTO_UPDATE) && auto_update_en_in && update_differs) begin
               start_op = OP_AUTO_UPDATE;
            end
         end
      end
   end

   // Power-up check runs once after the role is known
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pu_pend_r <= 1'b1;
      end else if (role_valid_r) begin
         pu_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         busy_r <= 1'b0;
         op_r   <= OP_NONE;
      end else if (start_op != OP_NONE) begin
         busy_r <= 1'b1;
         op_r   <= start_op;
      end else if (mst_state_r == M_DONE) begin
         busy_r <= 1'b0;
         op_r   <= OP_NONE;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         svc_reject_r            <= 1'b0;
         service_code_out        <= 7'h00;
         mailbox_word_offset_out <= 9'h000;
      end else begin
         svc_reject_r <= svc_valid_in && (start_op == OP_NONE);
         if (svc_valid_in && (start_op != OP_NONE)) begin
            service_code_out        <= svc_code;
            mailbox_word_offset_out <= svc_descriptor_in[`SVC_OFFSET_MSB:`SVC_OFFSET_LSB];
         end
      end
   end

   // Fractional divider: 40 ticks per 50 cycles gives a 20 MHz average clock
   assign acc_sum  = acc_r + `SCK_ACC_STEP;
   assign acc_tick = (acc_sum >= `SCK_ACC_MOD);
   assign tick     = acc_tick && !(pend_r && !fifo_in_ready);

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         acc_r <= 7'h00;
      end else if (acc_tick) begin
         acc_r <= acc_sum - `SCK_ACC_MOD;
      end else begin
         acc_r <= acc_sum;
      end
   end

   assign launch = tick && (mst_state_r == M_DATA) && !sck_r && (remain_r != 19'h00000);

   // Flash read in mode 3: clock idles high, output on falling, sample on rising
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mst_state_r <= M_IDLE;
         shift_r     <= 32'h00000000;
         bits_r      <= 6'h00;
         remain_r    <= 19'h00000;
         sck_r       <= 1'b1;
         ss_n_r      <= 1'b1;
         sdo_r       <= 1'b0;
      end else begin
         unique case (mst_state_r)
            M_IDLE: begin
               sck_r <= 1'b1;
               sdo_r <= slave_ok ? overrun_r : 1'b0;
               if (start_op != OP_NONE) begin
                  ss_n_r      <= 1'b0;
                  shift_r     <= {`FLASH_READ_CMD, image_addr_in};
                  bits_r      <= `CMD_BITS;
                  remain_r    <= {image_len_in, 3'h0};
                  mst_state_r <= M_CMD;
               end
            end
            M_CMD: begin
               if (tick) begin
                  if (sck_r) begin
                     sck_r   <= 1'b0;
                     sdo_r   <= shift_r[31];
                     shift_r <= {shift_r[30:0], 1'b0};
                     bits_r  <= bits_r - 6'h01;
                  end else begin
                     sck_r <= 1'b1;
                     if (bits_r == 6'h00) begin
                        mst_state_r <= M_DATA;
                     end
                  end
               end
            end
            M_DATA: begin
               if (launch) begin
                  sck_r    <= 1'b1;
                  remain_r <= remain_r - 19'h00001;
               end else if (tick && sck_r && (remain_r != 19'h00000)) begin
                  sck_r <= 1'b0;
               end else if (sck_r && (remain_r == 19'h00000) && (samp_dly_r == 2'h0) && !pend_r) begin
                  ss_n_r      <= 1'b1;
                  mst_state_r <= M_DONE;
               end
            end
            M_DONE: begin
               mst_state_r <= M_IDLE;
            end
         endcase
      end
   end

   // Sample delay matches the two-flop latency of the data input
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         samp_dly_r <= 2'h0;
      end else begin
         samp_dly_r <= {samp_dly_r[0], launch};
      end
   end

   // Shared byte assembly for both roles
   assign bit_take = master_role ? samp_dly_r[1] :
                     (slave_ok && !busy_r && !ss_s && sck_s && !sck_prev_r);
   assign byte_done   = bit_take && (rxbits_r == `BYTE_LAST_BIT);
   assign overrun_set = byte_done && pend_r && !fifo_in_ready;

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_r     <= 8'h00;
         rxbits_r <= 3'h0;
      end else if (!master_role && ss_s) begin
         rxbits_r <= 3'h0;
      end else if (bit_take) begin
         rx_r     <= {rx_r[6:0], sdi_s};
         rxbits_r <= rxbits_r + 3'h1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pend_r      <= 1'b0;
         pend_data_r <= 8'h00;
      end else if (byte_done && !overrun_set) begin
         pend_r      <= 1'b1;
         pend_data_r <= {rx_r[6:0], sdi_s};
      end else if (fifo_in_ready) begin
         pend_r <= 1'b0;
      end
   end

   // Overrun is sticky; a new overrun wins over a clear in the same cycle
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         overrun_r <= 1'b0;
      end else if (overrun_set) begin
         overrun_r <= 1'b1;
      end else if (overrun_clr_in) begin
         overrun_r <= 1'b0;
      end
   end

   spi_stream_fifo #(
      .WIDTH (`FIFO_WIDTH),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_in    (ref_clk_in),
      .rstn_in       (rstn_in),
      .in_valid_in   (pend_r),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (pend_data_r),
      .out_valid_out (data_valid_out),
      .out_ready_in  (data_ready_in),
      .out_data_out  (data_out)
   );

   // Pin drive and fabric handover
   assign fabric_owns_out = master_ok && powerup_done_in && !busy_r && !pu_pend_r;
   assign ss_level        = fabric_owns_out ? fabric_ss_n_in : ss_n_r;
   assign drive_m         = master_ok && !ss_level;
   assign sck_out         = fabric_owns_out ? fabric_sck_in : sck_r;
   assign ss_n_out        = ss_level;
   assign sdo_out         = fabric_owns_out ? fabric_sdo_in : sdo_r;
   assign sck_oe_out      = drive_m;
   assign ss_n_oe_out     = drive_m;
   assign sdo_oe_out      = drive_m || (slave_ok && !ss_s);
   assign fabric_sdi_out  = sdi_s;

   assign role_master_out         = master_role;
   assign design_init_allowed_out = master_role;
   assign jtag_grant_out          = jtag_prog_req_in && !busy_r;
   assign busy_out                = busy_r;
   assign op_out                  = op_r;
   assign svc_reject_out          = svc_reject_r;
   assign slave_overrun_out       = overrun_r;

   AST_ROLE_HELD: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      $past(role_valid_r) |-> $stable(role_r))
      else $error("role changed after capture");

   AST_EN_LOW_TRISTATE: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      !en_s |-> !sck_oe_out && !ss_n_oe_out && !sdo_oe_out)
      else $error("output driven while enable low");

   AST_SS_HIGH_TRISTATE: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      ((master_role && ss_n_out) || (!master_role && ss_s)) |-> !sck_oe_out && !sdo_oe_out)
      else $error("output driven while select high");

   AST_SLAVE_NO_FABRIC: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (role_valid_r && role_r == `ROLE_SLAVE) |-> !fabric_owns_out && !sck_oe_out)
      else $error("fabric or clock drive in slave role");

   AST_CLK_IDLE_HIGH: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (mst_state_r == M_IDLE) |-> sck_r && ss_n_r)
      else $error("master clock not idle high");

   AST_SCK_RATE: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      !acc_tick |=> acc_tick ##1 acc_tick)
      else $error("clock divider off rate");

   AST_MASTER_NEEDS_ROLE: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      $rose(busy_r) |-> $past(master_ok))
      else $error("master job without master role and enable");

   AST_IN_APP_BY_REQUEST: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      ($rose(busy_r) && op_r == OP_IN_APP) |-> $past(svc_valid_in) && !$past(pu_pend_r))
      else $error("in-application job without request");

   AST_UPDATE_ENABLED: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      ($rose(busy_r) && op_r == OP_AUTO_UPDATE) |-> $past(auto_update_en_in && update_differs))
      else $error("auto update started while disabled or same version");

   AST_BUSY_ATOMIC: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      busy_r |-> !jtag_grant_out)
      else $error("JTAG granted during job");

   AST_OP_HELD: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      busy_r |=> !busy_r || $stable(op_r))
      else $error("job changed while running");

   AST_SLAVE_NEEDS_ROLE: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      ($rose(pend_r) && !master_role) |-> $past(slave_ok))
      else $error("slave byte taken without slave role and enable");

endmodule

/* File: spi_flash_model.sv */
// Behavioural serial flash that answers mode 3 read commands
`timescale 1ns/1ps
module spi_flash_model (
   input  wire logic sck_in,
   input  wire logic ss_n_in,
   input  wire logic mosi_in,
   output logic      miso_out
);
   logic [31:0] cmd_r;
   logic [7:0]  byte_r;
   int          bit_cnt;
   initial begin
      miso_out = 1'b0;
      cmd_r = 32'h0;
      bit_cnt = 0;
   end
   // Released line shows the inverse of its last bit
   always @(posedge ss_n_in) begin
      bit_cnt = 0;
      miso_out = ~miso_out;
   end
   // Command and address taken on the rising clock, MSB first
   always @(posedge sck_in) if (!ss_n_in && bit_cnt < 32) begin
      cmd_r = {cmd_r[30:0], mosi_in};
      bit_cnt = bit_cnt + 1;
   end
   // Data changes on the falling clock; byte k is address low byte plus k
   always @(negedge sck_in) if (!ss_n_in && bit_cnt >= 32) begin
      byte_r = cmd_r[7:0] + 8'((bit_cnt - 32) / 8);
      miso_out = (cmd_r[31:24] == 8'h03) ? byte_r[7 - (bit_cnt - 32) % 8] : ~miso_out;
      bit_cnt = bit_cnt + 1;
   end
endmodule

/* File: spi_programming_port_control_bench.sv */
// Self-checking bench for the SPI programming port control block
`timescale 1ns/1ps
`include "spi_prog_defines.svh"
module spi_programming_port_control_bench
   import spi_prog_pkg::*;
();
   logic        clk, rstn, en, strap, pdone, blank, pfail, au_en, svc_v, jreq, oclr, rdy, stall;
   logic        b_sck, b_ss_n, b_sdi, f_sck, f_sdo, f_ss_n, f_sdi, m_sdi, sck_w, ss_w;
   logic        rej, grant, sck_o, sck_oe, ss_o, ss_oe, sdo, sdo_oe, owns, mst, init_ok, busy, vld, ovr;
   logic [15:0] uver, pver, ilen, desc;
   logic [23:0] iaddr;
   logic [6:0]  code, s_code;
   logic [8:0]  off, s_off;
   logic [7:0]  dat, b;
   prog_op_t    op;
   logic [7:0]  exp_q[$];
   int          fail_count, cmp_count;
   assign sck_w = sck_oe ? sck_o : b_sck;
   assign ss_w = ss_oe ? ss_o : b_ss_n;
   spi_programming_port_control i_dut (
      .ref_clk_in(clk), .rstn_in(rstn), .spi_en_in(en), .interface_role_strap_in(strap), .powerup_done_in(pdone),
      .device_blank_in(blank), .power_fail_seen_in(pfail), .auto_update_en_in(au_en), .update_version_in(uver),
      .programmed_version_in(pver), .image_addr_in(iaddr), .image_len_in(ilen), .svc_valid_in(svc_v),
      .svc_descriptor_in(desc), .svc_reject_out(rej), .service_code_out(s_code), .mailbox_word_offset_out(s_off),
      .jtag_prog_req_in(jreq), .jtag_grant_out(grant), .sck_in(sck_w), .sck_out(sck_o), .sck_oe_out(sck_oe),
      .ss_n_in(ss_w), .ss_n_out(ss_o), .ss_n_oe_out(ss_oe), .sdi_in(mst ? m_sdi : b_sdi), .sdo_out(sdo),
      .sdo_oe_out(sdo_oe), .fabric_sck_in(f_sck), .fabric_ss_n_in(f_ss_n), .fabric_sdo_in(f_sdo),
      .fabric_sdi_out(f_sdi), .fabric_owns_out(owns), .role_master_out(mst), .design_init_allowed_out(init_ok),
      .busy_out(busy), .op_out(op), .data_valid_out(vld), .data_ready_in(rdy), .data_out(dat),
      .overrun_clr_in(oclr), .slave_overrun_out(ovr));
   spi_flash_model i_flash (.sck_in(sck_w), .ss_n_in(ss_w), .mosi_in(sdo), .miso_out(m_sdi));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (exp !== got) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic finish_test();
      if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic do_reset(input logic s, input logic bl, input logic pf);
      @(negedge clk);
      rstn = 1'b0;
      {strap, blank, pfail} = {s, bl, pf};
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      repeat (8) @(negedge clk);
   endtask
   task automatic svc(input logic [6:0] c, input logic [8:0] o);
      @(negedge clk);
      svc_v = 1'b1;
      desc = {o, c};
      @(negedge clk);
      svc_v = 1'b0;
   endtask
   task automatic wait_idle();
      for (int n = 0; n < 4000 && (busy !== 1'b0 || exp_q.size() != 0); n++) @(negedge clk);
      chk("idle", 32'h0, {busy, 16'(exp_q.size())});
   endtask
   // Prepares an image and the bytes the flash will return for it
   task automatic new_image();
      iaddr = 24'($urandom);
      ilen = 16'(1 + $urandom % 4);
      for (int k = 0; k < ilen; k++) exp_q.push_back(iaddr[7:0] + 8'(k));
   endtask
   task automatic slave_byte(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         b_sck = 1'b0;
         b_sdi = v[i];
         repeat (4) @(negedge clk);
         b_sck = 1'b1;
         repeat (4) @(negedge clk);
      end
   endtask
   always @(negedge clk) begin
      rdy <= stall ? 1'b0 : 1'($urandom);
      f_sck <= 1'($urandom);
      f_sdo <= 1'($urandom);
   end
   always @(posedge clk) if (rstn && vld === 1'b1 && rdy === 1'b1) begin
      if (exp_q.size() == 0) chk("extra byte", 32'h0, {24'h0, dat});
      else chk("stream byte", {24'h0, exp_q.pop_front()}, {24'h0, dat});
   end
   initial begin
      #1000000;
      fail_count++;
      finish_test();
   end
   initial begin
      void'($urandom(32'hf4fd934b));
      {rstn, strap, pdone, blank, pfail, au_en, svc_v, jreq, oclr, stall, rdy, f_sck, f_sdo, b_sdi} = '0;
      {en, b_sck, b_ss_n, f_ss_n} = '1;
      {desc, uver, pver, ilen, iaddr} = '0;
      do_reset(1'b1, 1'b0, 1'b0);
      chk("owns early", 32'h0, owns);
      chk("role", 32'({2'b11, OP_NONE}), {mst, init_ok, op});
      pdone = 1'b1;
      repeat (3) @(negedge clk);
      chk("fabric", {28'h1, f_sck, f_sdo, m_sdi}, {owns, sck_o, sdo, f_sdi});
      f_ss_n = 1'b0;
      @(negedge clk);
      chk("fabric select", 32'h6, {ss_oe, sck_oe, ss_o});
      f_ss_n = 1'b1;
      uver = 16'($urandom);
      for (int i = 0; i < 5; i++) begin
         au_en = (i != 0);
         pver = (i == 1) ? uver : ~uver;
         code = (i == 2) ? 7'h7f : (i == 4) ? `SVC_IN_APP : `SVC_AUTO_UPDATE;
         off = 9'($urandom);
         if (i >= 3) new_image();
         svc(code, off);
         chk("reject", 32'(i < 3), rej);
         if (i >= 3) begin
            chk("job", {(i == 3) ? OP_AUTO_UPDATE : OP_IN_APP, code, off}, {op, s_code, s_off});
            chk("sck idle", 32'h1, sck_o);
            jreq = 1'b1;
            svc(`SVC_IN_APP, 9'h0);
            chk("atomic", 32'h1, {grant, rej});
            chk("master pins", 32'h2, {sck_oe, ss_o});
            jreq = 1'b0;
            wait_idle();
         end
      end
      new_image();
      do_reset(1'b1, 1'b1, 1'b0);
      chk("auto prog", OP_AUTO_PROG, op);
      wait_idle();
      new_image();
      do_reset(1'b1, 1'b1, 1'b1);
      chk("recovery", OP_RECOVERY, op);
      wait_idle();
      do_reset(1'b0, 1'b1, 1'b0);
      strap = 1'b1;
      repeat (6) @(negedge clk);
      chk("slave role", 32'h0, {mst, init_ok, owns, op, sdo_oe});
      svc(`SVC_IN_APP, 9'h0);
      chk("slave svc", 32'h1, {busy, rej});
      stall = 1'b1;
      b_ss_n = 1'b0;
      for (int n = 0; n < 35; n++) begin
         b = 8'($urandom);
         if (n < 34) exp_q.push_back(b);
         slave_byte(b);
      end
      chk("overrun", 32'h7, {ovr, sdo_oe, sdo});
      b_ss_n = 1'b1;
      stall = 1'b0;
      wait_idle();
      oclr = 1'b1;
      @(negedge clk);
      oclr = 1'b0;
      en = 1'b0;
      b_ss_n = 1'b0;
      slave_byte(8'h5a);
      chk("disabled", 32'h0, {ovr, sdo_oe, sck_oe, ss_oe});
      finish_test();
   end
endmodule
